// file: timeout_flush_gasket.v
// timeout flush gasket between a source initiator and a destination target
// assumes one outstanding read and one outstanding write per channel, responses matched by id,
// all ports synchronous to CLK_I
//
// Function
// - every flushed command answers with timeout error, debug writes included.
// - read and write timing out together advance timeout count by two.
// - simultaneous unexpected read and write responses advance count by two.
// - both counters saturate at three and never wrap.
// - only the first timed-out command's details are captured.
// - responses matching no outstanding command are dropped, not forwarded.
// - write timing out on final accepted beat still drains and responds.
// - timeout period resets to three times two to the thirtieth cycles.
`timescale 1ns/1ns
`default_nettype none
`include "flush_gasket_map.vh"
module timeout_flush_gasket #(
  parameter ID_W = `TFG_ID_W,
  parameter PW = `TFG_PERIOD_W
) (
  // clock, reset, enable
  input wire CLK_I,
  input wire RST_I,
  input wire CE_I,
  // period control
  input wire PERIOD_LOAD_I,
  input wire [PW-1:0] PERIOD_I,
  // source side read command and response
  input wire S_RCMD_VALID_I,
  input wire [ID_W-1:0] S_RCMD_ID_I,
  input wire S_RCMD_DEBUG_I,
  output reg S_RCMD_READY_O,
  output reg S_RRESP_VALID_O,
  output reg [1:0] S_RRESP_CODE_O,
  output reg [ID_W-1:0] S_RRESP_ID_O,
  input wire S_RRESP_READY_I,
  // source side write command, data, response
  input wire S_WCMD_VALID_I,
  input wire [ID_W-1:0] S_WCMD_ID_I,
  input wire S_WCMD_DEBUG_I,
  output reg S_WCMD_READY_O,
  input wire S_WDATA_VALID_I,
  input wire S_WDATA_LAST_I,
  output reg S_WDATA_READY_O,
  output reg S_WRESP_VALID_O,
  output reg [1:0] S_WRESP_CODE_O,
  output reg [ID_W-1:0] S_WRESP_ID_O,
  input wire S_WRESP_READY_I,
  // destination side read
  output reg D_RCMD_VALID_O,
  output reg [ID_W-1:0] D_RCMD_ID_O,
  input wire D_RCMD_READY_I,
  input wire D_RRESP_VALID_I,
  input wire [ID_W-1:0] D_RRESP_ID_I,
  input wire [1:0] D_RRESP_CODE_I,
  // destination side write
  output reg D_WCMD_VALID_O,
  output reg [ID_W-1:0] D_WCMD_ID_O,
  input wire D_WCMD_READY_I,
  output reg D_WDATA_VALID_O,
  output reg D_WDATA_LAST_O,
  input wire D_WDATA_READY_I,
  input wire D_WRESP_VALID_I,
  input wire [ID_W-1:0] D_WRESP_ID_I,
  input wire [1:0] D_WRESP_CODE_I,
  // status
  output reg [1:0] TIMEOUT_COUNT_O,
  output reg [1:0] UNEXP_COUNT_O,
  output reg CAPT_VALID_O,
  output reg CAPT_IS_WRITE_O,
  output reg CAPT_DEBUG_O,
  output reg [ID_W-1:0] CAPT_ID_O
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_BUSY = 2'h1;
  localparam [1:0] ST_FLUSH = 2'h2;
  localparam [1:0] ST_RESP = 2'h3;

  reg [PW-1:0] period_r;
  reg [1:0] rst_r, wst_r;
  reg [PW-1:0] rage_r, wage_r;
  reg [ID_W-1:0] rid_r, wid_r;
  reg rdbg_r, wdbg_r;
  reg wdata_done_r;
  wire [1:0] tcnt_w, ucnt_w;

  wire rto_w = (rst_r == ST_BUSY) && (rage_r >= period_r - 1'b1);
  wire wto_w = (wst_r == ST_BUSY) && (wage_r >= period_r - 1'b1);
  wire rmatch_w = (rst_r == ST_BUSY) && (rid_r == D_RRESP_ID_I);
  wire wmatch_w = (wst_r == ST_BUSY) && (wid_r == D_WRESP_ID_I);
  wire runexp_w = D_RRESP_VALID_I && !rmatch_w;
  wire wunexp_w = D_WRESP_VALID_I && !wmatch_w;
  wire s_wbeat_w = S_WDATA_VALID_I && S_WDATA_READY_O;

  sat_err_counter u_tcnt (
    .clk_i(CLK_I), .rst_i(RST_I), .ce_i(CE_I),
    .ev_a_i(rto_w), .ev_b_i(wto_w), .count_o(tcnt_w)
  );
  sat_err_counter u_ucnt (
    .clk_i(CLK_I), .rst_i(RST_I), .ce_i(CE_I),
    .ev_a_i(runexp_w), .ev_b_i(wunexp_w), .count_o(ucnt_w)
  );

  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      period_r <= `TFG_PERIOD_DEFAULT;
      rst_r <= ST_IDLE;
      wst_r <= ST_IDLE;
      rage_r <= {PW{1'b0}};
      wage_r <= {PW{1'b0}};
      rid_r <= {ID_W{1'b0}};
      wid_r <= {ID_W{1'b0}};
      rdbg_r <= 1'b0;
      wdbg_r <= 1'b0;
      wdata_done_r <= 1'b0;
      S_RCMD_READY_O <= 1'b0;
      S_RRESP_VALID_O <= 1'b0;
      S_RRESP_CODE_O <= `TFG_RESP_OK;
      S_RRESP_ID_O <= {ID_W{1'b0}};
      S_WCMD_READY_O <= 1'b0;
      S_WDATA_READY_O <= 1'b0;
      S_WRESP_VALID_O <= 1'b0;
      S_WRESP_CODE_O <= `TFG_RESP_OK;
      S_WRESP_ID_O <= {ID_W{1'b0}};
      D_RCMD_VALID_O <= 1'b0;
      D_RCMD_ID_O <= {ID_W{1'b0}};
      D_WCMD_VALID_O <= 1'b0;
      D_WCMD_ID_O <= {ID_W{1'b0}};
      D_WDATA_VALID_O <= 1'b0;
      D_WDATA_LAST_O <= 1'b0;
      TIMEOUT_COUNT_O <= 2'h0;
      UNEXP_COUNT_O <= 2'h0;
      CAPT_VALID_O <= 1'b0;
      CAPT_IS_WRITE_O <= 1'b0;
      CAPT_DEBUG_O <= 1'b0;
      CAPT_ID_O <= {ID_W{1'b0}};
    end else if (CE_I) begin
      TIMEOUT_COUNT_O <= tcnt_w;
      UNEXP_COUNT_O <= ucnt_w;
      if (PERIOD_LOAD_I && PERIOD_I != {PW{1'b0}})
        period_r <= PERIOD_I;
      if (!CAPT_VALID_O && (rto_w || wto_w)) begin
        CAPT_VALID_O <= 1'b1;
        CAPT_IS_WRITE_O <= !rto_w;
        CAPT_DEBUG_O <= rto_w ? rdbg_r : wdbg_r;
        CAPT_ID_O <= rto_w ? rid_r : wid_r;
      end
      // read channel
      S_RCMD_READY_O <= (rst_r == ST_IDLE) && !S_RCMD_READY_O;
      case (rst_r)
        ST_IDLE: begin
          if (S_RCMD_VALID_I && S_RCMD_READY_O) begin
            rst_r <= ST_BUSY;
            rid_r <= S_RCMD_ID_I;
            rdbg_r <= S_RCMD_DEBUG_I;
            rage_r <= {PW{1'b0}};
            S_RCMD_READY_O <= 1'b0;
            D_RCMD_VALID_O <= 1'b1;
            D_RCMD_ID_O <= S_RCMD_ID_I;
          end
        end
        ST_BUSY: begin
          rage_r <= rage_r + 1'b1;
          if (D_RCMD_READY_I)
            D_RCMD_VALID_O <= 1'b0;
          if (rto_w) begin
            D_RCMD_VALID_O <= 1'b0;
            rst_r <= ST_RESP;
            S_RRESP_VALID_O <= 1'b1;
            S_RRESP_CODE_O <= `TFG_RESP_TIMEOUT;
            S_RRESP_ID_O <= rid_r;
          end else if (D_RRESP_VALID_I && rmatch_w) begin
            rst_r <= ST_RESP;
            S_RRESP_VALID_O <= 1'b1;
            S_RRESP_CODE_O <= D_RRESP_CODE_I;
            S_RRESP_ID_O <= rid_r;
          end
        end
        default: begin
          if (S_RRESP_READY_I) begin
            S_RRESP_VALID_O <= 1'b0;
            rst_r <= ST_IDLE;
          end
        end
      endcase
      // write channel
      S_WCMD_READY_O <= (wst_r == ST_IDLE) && !S_WCMD_READY_O;
      case (wst_r)
        ST_IDLE: begin
          if (S_WCMD_VALID_I && S_WCMD_READY_O) begin
            wst_r <= ST_BUSY;
            wid_r <= S_WCMD_ID_I;
            wdbg_r <= S_WCMD_DEBUG_I;
            wage_r <= {PW{1'b0}};
            wdata_done_r <= 1'b0;
            S_WCMD_READY_O <= 1'b0;
            S_WDATA_READY_O <= 1'b1;
            D_WCMD_VALID_O <= 1'b1;
            D_WCMD_ID_O <= S_WCMD_ID_I;
          end
        end
        ST_BUSY: begin
          wage_r <= wage_r + 1'b1;
          if (D_WCMD_READY_I)
            D_WCMD_VALID_O <= 1'b0;
          // forward data beat by beat; source stalls until destination takes it
          if (D_WDATA_VALID_O && D_WDATA_READY_I) begin
            D_WDATA_VALID_O <= 1'b0;
            S_WDATA_READY_O <= !D_WDATA_LAST_O;
          end
          if (s_wbeat_w) begin
            S_WDATA_READY_O <= 1'b0;
            D_WDATA_VALID_O <= 1'b1;
            D_WDATA_LAST_O <= S_WDATA_LAST_I;
          end
          // source burst complete is tracked apart from destination acceptance
          if (s_wbeat_w && S_WDATA_LAST_I)
            wdata_done_r <= 1'b1;
          if (wto_w) begin
            // drain source data independent of destination
            D_WCMD_VALID_O <= 1'b0;
            D_WDATA_VALID_O <= 1'b0;
            // keep taking source beats unless its last beat was already seen
            wdata_done_r <= wdata_done_r || (s_wbeat_w && S_WDATA_LAST_I);
            S_WDATA_READY_O <= !(wdata_done_r || (s_wbeat_w && S_WDATA_LAST_I));
            wst_r <= ST_FLUSH;
          end else if (D_WRESP_VALID_I && wmatch_w) begin
            wst_r <= ST_RESP;
            S_WDATA_READY_O <= 1'b0;
            S_WRESP_VALID_O <= 1'b1;
            S_WRESP_CODE_O <= D_WRESP_CODE_I;
            S_WRESP_ID_O <= wid_r;
          end
        end
        ST_FLUSH: begin
          // accept and discard rest of burst
          if (wdata_done_r || (s_wbeat_w && S_WDATA_LAST_I) || !S_WDATA_READY_O) begin
            S_WDATA_READY_O <= 1'b0;
            // debug writes still get timeout error
            S_WRESP_VALID_O <= 1'b1;
            S_WRESP_CODE_O <= `TFG_RESP_TIMEOUT;
            S_WRESP_ID_O <= wid_r;
            wst_r <= ST_RESP;
          end
        end
        default: begin
          if (S_WRESP_READY_I) begin
            S_WRESP_VALID_O <= 1'b0;
            wst_r <= ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: flush_gasket_map.vh
// constants for the bus timeout flush gasket
// assumes a single bus clock domain
`ifndef FLUSH_GASKET_MAP_VH
`define FLUSH_GASKET_MAP_VH
// default timeout period: 3 x 2^30 cycles
`define TFG_PERIOD_DEFAULT 32'hc0000000
`define TFG_PERIOD_W 32
`define TFG_CNT_W 2
`define TFG_CNT_MAX 2'h3
// response codes
`define TFG_RESP_OK 2'h0
`define TFG_RESP_TIMEOUT 2'h2
`define TFG_ID_W 4
`endif

// file: sat_err_counter.v
// saturating two-bit error counter, adds 0, 1 or 2 per cycle
// assumes inputs are synchronous to CLK
`timescale 1ns/1ns
`default_nettype none
`include "flush_gasket_map.vh"
module sat_err_counter (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire ev_a_i,
  input wire ev_b_i,
  output reg [1:0] count_o
);
  wire [2:0] sum_w;
  assign sum_w = {1'b0, count_o} + {2'h0, ev_a_i} + {2'h0, ev_b_i};
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_o <= 2'h0;
    end else if (ce_i) begin
      if (sum_w > {1'b0, `TFG_CNT_MAX})
        count_o <= `TFG_CNT_MAX;
      else
        count_o <= sum_w[1:0];
    end
  end
endmodule
`default_nettype wire

// file: gasket_monitor.sv
// checker on the gasket ports
// assumes one clock, async high reset, 4-bit ids
`timescale 1ns/1ns
`default_nettype none
module gasket_monitor (
  // clock, reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // responses
  input wire logic D_RRESP_VALID_I,
  input wire logic D_WRESP_VALID_I,
  input wire logic S_RRESP_VALID_O,
  input wire logic [1:0] S_RRESP_CODE_O,
  input wire logic S_WRESP_VALID_O,
  input wire logic [1:0] S_WRESP_CODE_O,
  // status
  input wire logic [1:0] TIMEOUT_COUNT_O,
  input wire logic [1:0] UNEXP_COUNT_O,
  input wire logic CAPT_VALID_O,
  input wire logic [3:0] CAPT_ID_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // answers raised with no target response behind them
  sequence own_r;
    $rose(S_RRESP_VALID_O) && !$past(D_RRESP_VALID_I);
  endsequence
  sequence own_w;
    $rose(S_WRESP_VALID_O) && !$past(D_WRESP_VALID_I);
  endsequence
  a_rd_self_err: assert property (own_r |-> S_RRESP_CODE_O == 2'h2)
    else $error("bad read code");
  a_wr_self_err: assert property (own_w |-> S_WRESP_CODE_O == 2'h2)
    else $error("bad write code");
  a_to_no_fall: assert property (TIMEOUT_COUNT_O >= $past(TIMEOUT_COUNT_O))
    else $error("timeout count fell");
  a_ux_no_fall: assert property (UNEXP_COUNT_O >= $past(UNEXP_COUNT_O))
    else $error("unexp count fell");
  a_to_sat_hold: assert property (TIMEOUT_COUNT_O == 2'h3 |=> TIMEOUT_COUNT_O == 2'h3)
    else $error("timeout count wrapped");
  a_ux_sat_hold: assert property (UNEXP_COUNT_O == 2'h3 |=> UNEXP_COUNT_O == 2'h3)
    else $error("unexp count wrapped");
  a_capt_kept: assert property (CAPT_VALID_O |=> CAPT_VALID_O && $stable(CAPT_ID_O))
    else $error("capture overwritten");
  a_capt_counted: assert property ($rose(CAPT_VALID_O) |-> ##[0:2] TIMEOUT_COUNT_O != 2'h0)
    else $error("capture not counted");
endmodule
`default_nettype wire

// file: dest_target.sv
// destination target model
// answers lat_i + 1 cycles after taking a read command or last write beat
`timescale 1ns/1ns
`default_nettype none
module dest_target (
  // clock, reset, control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] lat_i,
  input wire logic stray_i,
  // read
  input wire logic rcmd_valid_i,
  input wire logic [3:0] rcmd_id_i,
  output logic rcmd_ready_o,
  output logic rresp_valid_o,
  output logic [3:0] rresp_id_o,
  // write
  input wire logic wcmd_valid_i,
  input wire logic [3:0] wcmd_id_i,
  input wire logic wdata_valid_i,
  input wire logic wdata_last_i,
  output logic w_ready_o,
  output logic wresp_valid_o,
  output logic [3:0] wresp_id_o
);
  logic rb_r, wb_r;
  logic [7:0] rc_r, wc_r;
  logic [3:0] rid_r, wid_r;
  assign rcmd_ready_o = !rb_r;
  assign w_ready_o = !wb_r;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {rb_r, wb_r, rc_r, wc_r, rid_r, wid_r} <= '0;
      {rresp_valid_o, wresp_valid_o, rresp_id_o, wresp_id_o} <= '0;
    end else begin
      rc_r <= rc_r - 8'h1;
      wc_r <= wc_r - 8'h1;
      rresp_valid_o <= stray_i | rb_r & rc_r == 8'h0;
      wresp_valid_o <= stray_i | wb_r & wc_r == 8'h0;
      // idle id lines keep toggling
      rresp_id_o <= stray_i ? 4'hf : rb_r & rc_r == 8'h0 ? rid_r : ~rresp_id_o;
      wresp_id_o <= stray_i ? 4'hf : wb_r & wc_r == 8'h0 ? wid_r : ~wresp_id_o;
      if (rb_r & rc_r == 8'h0) rb_r <= 1'b0;
      if (wb_r & wc_r == 8'h0) wb_r <= 1'b0;
      if (rcmd_valid_i & !rb_r) begin
        rb_r <= 1'b1;
        rid_r <= rcmd_id_i;
        rc_r <= lat_i;
      end
      if (wcmd_valid_i & !wb_r) wid_r <= wcmd_id_i;
      if (wdata_valid_i & wdata_last_i & !wb_r) begin
        wb_r <= 1'b1;
        wc_r <= lat_i;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb_top.sv
// bench for the gasket with target model and checker
// assumes source response readies held high
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic CLK_I = 0, RST_I = 1, PERIOD_LOAD_I = 0, stray = 0;
  logic S_RCMD_VALID_I = 0, S_RCMD_DEBUG_I = 0, S_WCMD_VALID_I = 0, S_WCMD_DEBUG_I = 0;
  logic S_WDATA_VALID_I = 0, S_WDATA_LAST_I = 0, S_RCMD_READY_O, S_RRESP_VALID_O;
  logic S_WCMD_READY_O, S_WDATA_READY_O, S_WRESP_VALID_O, D_RCMD_VALID_O, D_WCMD_VALID_O;
  logic D_WDATA_VALID_O, D_WDATA_LAST_O, CAPT_VALID_O, CAPT_IS_WRITE_O, CAPT_DEBUG_O;
  logic D_RCMD_READY_I, D_RRESP_VALID_I, D_WDATA_READY_I, D_WRESP_VALID_I;
  logic [3:0] S_RCMD_ID_I = 0, S_WCMD_ID_I = 0, D_RRESP_ID_I, D_WRESP_ID_I, CAPT_ID_O;
  logic [3:0] S_RRESP_ID_O, S_WRESP_ID_O, D_RCMD_ID_O, D_WCMD_ID_O;
  logic [1:0] S_RRESP_CODE_O, S_WRESP_CODE_O, TIMEOUT_COUNT_O, UNEXP_COUNT_O;
  logic [31:0] PERIOD_I = 32'h0;
  logic [7:0] lat = 8'h3;
  logic [5:0] r_last, w_last;
  int r_seen = 0, w_seen = 0, err_total = 0, tests_run = 0;
  timeout_flush_gasket dut (.*, .CE_I(1'b1), .S_RRESP_READY_I(1'b1), .S_WRESP_READY_I(1'b1),
    .D_RRESP_CODE_I(2'h0), .D_WRESP_CODE_I(2'h0), .D_WCMD_READY_I(D_WDATA_READY_I));
  dest_target far (.clk_i(CLK_I), .rst_i(RST_I), .lat_i(lat), .stray_i(stray),
    .rcmd_valid_i(D_RCMD_VALID_O), .rcmd_id_i(D_RCMD_ID_O), .rcmd_ready_o(D_RCMD_READY_I),
    .rresp_valid_o(D_RRESP_VALID_I), .rresp_id_o(D_RRESP_ID_I), .wcmd_valid_i(D_WCMD_VALID_O),
    .wcmd_id_i(D_WCMD_ID_O), .wdata_valid_i(D_WDATA_VALID_O), .wdata_last_i(D_WDATA_LAST_O),
    .w_ready_o(D_WDATA_READY_I), .wresp_valid_o(D_WRESP_VALID_I), .wresp_id_o(D_WRESP_ID_I));
  initial forever #20 CLK_I = ~CLK_I;
  always @(posedge CLK_I) begin
    if (S_RRESP_VALID_O) r_seen <= r_seen + 1;
    if (S_RRESP_VALID_O) r_last <= {S_RRESP_CODE_O, S_RRESP_ID_O};
    if (S_WRESP_VALID_O) w_seen <= w_seen + 1;
    if (S_WRESP_VALID_O) w_last <= {S_WRESP_CODE_O, S_WRESP_ID_O};
  end
  task automatic give_verdict;
    $display("mismatches %0d of %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // hold a request until its ready is seen, then drop it
  task automatic hs(input int k);
    int n;
    for (n = 0; n < 80; n++) begin
      @(negedge CLK_I);
      if ((k == 0 ? S_RCMD_READY_O : k == 1 ? S_WCMD_READY_O : S_WDATA_READY_O) === 1'b1) break;
    end
    if (n == 80) begin
      chk(6'h0, 6'h1);
      give_verdict();
    end
    @(posedge CLK_I);
    if (k == 0) S_RCMD_VALID_I <= 1'b0;
    if (k == 1) S_WCMD_VALID_I <= 1'b0;
    if (k == 2) S_WDATA_VALID_I <= 1'b0;
  endtask
  task automatic txn(input logic rd, wr, input logic [3:0] id, input logic dbg,
                     input int beats, gap, input logic [1:0] code);
    int r0, w0, b, n;
    repeat (3) @(posedge CLK_I);
    r0 = r_seen;
    w0 = w_seen;
    {S_RCMD_VALID_I, S_WCMD_VALID_I, S_RCMD_DEBUG_I, S_WCMD_DEBUG_I} <= {rd, wr, dbg, dbg};
    {S_RCMD_ID_I, S_WCMD_ID_I} <= {id, id};
    fork
      if (rd) hs(0);
      if (wr) hs(1);
    join
    for (b = 1; b <= beats && wr; b++) begin
      repeat (gap + 1) @(posedge CLK_I);
      S_WDATA_VALID_I <= 1'b1;
      S_WDATA_LAST_I <= (b == beats);
      hs(2);
    end
    for (n = 0; n < 300 && (r_seen - r0 < rd || w_seen - w0 < wr); n++) @(posedge CLK_I);
    if (n == 300) begin
      chk(6'h0, 6'h1);
      give_verdict();
    end
    if (rd) chk(r_last, {code, id});
    if (wr) chk(w_last, {code, id});
  endtask
  task automatic t_start;
    chk({TIMEOUT_COUNT_O, UNEXP_COUNT_O, CAPT_VALID_O, 1'b0}, 6'h0);
    {PERIOD_LOAD_I, PERIOD_I} <= {1'b1, 32'h14};
    @(posedge CLK_I);
    PERIOD_LOAD_I <= 1'b0;
    txn(1'b1, 1'b1, 4'h3, 1'b0, 2, 0, 2'h0);
  endtask
  task automatic t_rd_late;
    lat <= 8'h3c;
    txn(1'b1, 1'b0, 4'h5, 1'b0, 0, 0, 2'h2);
    repeat (70) @(posedge CLK_I);
    chk({CAPT_VALID_O, CAPT_IS_WRITE_O, CAPT_ID_O}, 6'h25);
    chk({TIMEOUT_COUNT_O, UNEXP_COUNT_O, 2'(r_seen)}, 6'h16);
  endtask
  task automatic t_stray;
    stray <= 1'b1;
    @(posedge CLK_I);
    stray <= 1'b0;
    repeat (4) @(posedge CLK_I);
    chk({UNEXP_COUNT_O, 2'(r_seen + w_seen), 2'h0}, 6'h3c);
  endtask
  task automatic t_dual;
    txn(1'b1, 1'b1, 4'h9, 1'b1, 1, 0, 2'h2);
    repeat (80) @(posedge CLK_I);
    chk({TIMEOUT_COUNT_O, UNEXP_COUNT_O, CAPT_DEBUG_O, 1'b0}, 6'h3c);
    txn(1'b1, 1'b0, 4'h2, 1'b0, 0, 0, 2'h2);
    chk({TIMEOUT_COUNT_O, CAPT_VALID_O, CAPT_IS_WRITE_O, CAPT_ID_O[1:0]}, 6'h39);
  endtask
  task automatic t_edge;
    // odd period so the final destination beat can meet the timeout edge (gap 8)
    lat <= 8'h0;
    {PERIOD_LOAD_I, PERIOD_I} <= {1'b1, 32'h15};
    @(posedge CLK_I);
    PERIOD_LOAD_I <= 1'b0;
    for (int g = 4; g < 12; g++) txn(1'b0, 1'b1, 4'(g), 1'b0, 2, g, g < 7 ? 2'h0 : 2'h2);
  endtask
  initial begin
    repeat (8) @(posedge CLK_I);
    RST_I <= 1'b0;
    t_start();
    t_rd_late();
    t_stray();
    t_dual();
    t_edge();
    give_verdict();
  end
endmodule
bind timeout_flush_gasket gasket_monitor mon (.CLK_I, .RST_I, .D_RRESP_VALID_I, .D_WRESP_VALID_I,
  .S_RRESP_VALID_O, .S_RRESP_CODE_O, .S_WRESP_VALID_O, .S_WRESP_CODE_O, .TIMEOUT_COUNT_O,
  .UNEXP_COUNT_O, .CAPT_VALID_O, .CAPT_ID_O);
`default_nettype wire
